// File: design/rnsi_top.sv
`timescale 1ns/100ps
// How it works
// RULE1 - voice call holds ring low until end
// RULE2 - data call holds ring low until end
// RULE3 - short message gives one 120ms low pulse
// RULE4 - unsolicited report gives 120ms low pulse
// RULE5 - originating call keeps ring line high (code: only from idle; a pulse or call already running stays low)
// RULE6 - lamp off while modem core stopped
// RULE7 - unregistered: 64ms on, 800ms off
// RULE8 - registered: 64ms on, 3000ms off
// RULE9 - packet data: 64ms on, 300ms off
// RULE10 - ring rests high; new event restarts pulse
// RULE11 - new cadence taken at next on-phase
module rnsi_top #(
  parameter int unsigned CYC_MS = rnsi_pkg::CYC_PER_MS
) (
  // clock, reset, enable
  input  wire logic               I_CORE_CLK,
  input  wire logic               I_NRST,
  input  wire logic               I_CE,
  // events from modem core (same clock)
  input  wire rnsi_pkg::rnsi_evt_t I_EVT,
  input  wire rnsi_pkg::rnsi_net_t I_NET,
  // indicator outputs
  output logic                    O_RING_N,
  output logic                    O_NETWORK_STATE_LAMP
);
  import rnsi_pkg::*;

  typedef enum logic [1:0] {
    RNSI_LAMP_OFF = 2'b00,
    RNSI_LAMP_ON  = 2'b01,
    RNSI_LAMP_GAP = 2'b10
  } rnsi_lamp_t;

  logic              ms_tick;
  logic [1:0]        ri_st_ff;
  logic [1:0]        nxt_ri_st;
  logic [MS_W-1:0]   ri_ms_ff;
  logic [MS_W-1:0]   nxt_ri_ms;
  rnsi_lamp_t        lamp_st_ff;
  rnsi_lamp_t        nxt_lamp_st;
  logic [MS_W-1:0]   lamp_ms_ff;
  logic [MS_W-1:0]   nxt_lamp_ms;
  rnsi_net_t         cad_ff;
  rnsi_net_t         nxt_cad;
  logic              ring_n_ff;
  logic              lamp_ff;

  // off-phase length for a given cadence
  function automatic logic [MS_W-1:0] off_ms(input rnsi_net_t n);
    case (n)
      RNSI_NET_UNREG: off_ms = MS_W'(OFF_UNREG_MS);
      RNSI_NET_REG:   off_ms = MS_W'(OFF_REG_MS);
      RNSI_NET_DATA:  off_ms = MS_W'(OFF_DATA_MS);
      default:        off_ms = MS_W'(OFF_UNREG_MS);
    endcase
  endfunction

  rnsi_ms_tick #(.CYC(CYC_MS)) u_tick (
    .i_clk  (I_CORE_CLK),
    .i_nrst (I_NRST),
    .i_ce   (I_CE),
    .o_tick (ms_tick)
  );

  // ring indicator sequencing
  always_comb begin
    nxt_ri_st = ri_st_ff;
    nxt_ri_ms = ri_ms_ff;
    case (ri_st_ff)
      RI_CALL: begin
        // RULE1 RULE2 call end releases
        if (I_EVT.call_end) begin
          nxt_ri_st = RI_IDLE;
        end
      end
      RI_PULSE: begin
        if (ms_tick) begin
          nxt_ri_ms = ri_ms_ff + MS_W'(1);
        end
        // RULE3 RULE4 120ms expiry
        if (ms_tick && ri_ms_ff == MS_W'(PULSE_MS - 1)) begin
          nxt_ri_st = RI_IDLE;
        end
      end
      default: nxt_ri_st = RI_IDLE;
    endcase
    // RULE10 pulse restart on event
    if (ri_st_ff != RI_CALL && (I_EVT.sms_rx || I_EVT.urc)) begin
      nxt_ri_st = RI_PULSE;
      nxt_ri_ms = '0;
    end
    // RULE1 RULE2 incoming call wins; RULE5 not when caller
    if (!I_EVT.originating && (I_EVT.voice_ring || I_EVT.data_ring)) begin
      nxt_ri_st = RI_CALL;
    end
    // RULE5 caller keeps idle line high
    if (I_EVT.originating && ri_st_ff == RI_IDLE) begin
      nxt_ri_st = RI_IDLE;
    end
  end

  // ring line is low in any non-idle state; registered output
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      ri_st_ff  <= RI_IDLE;
      ri_ms_ff  <= '0;
      ring_n_ff <= 1'b1;  // rests high from reset
    end else if (I_CE) begin
      ri_st_ff  <= nxt_ri_st;
      ri_ms_ff  <= nxt_ri_ms;
      // RULE10 high at rest
      ring_n_ff <= (nxt_ri_st == RI_IDLE);
    end
  end

  // lamp cadence engine
  always_comb begin
    nxt_lamp_st = lamp_st_ff;
    nxt_lamp_ms = lamp_ms_ff;
    nxt_cad     = cad_ff;
    if (ms_tick) begin
      nxt_lamp_ms = lamp_ms_ff + MS_W'(1);
    end
    case (lamp_st_ff)
      RNSI_LAMP_ON: begin
        // RULE7 RULE8 RULE9 64ms on-phase
        if (ms_tick && lamp_ms_ff == MS_W'(LAMP_ON_MS - 1)) begin
          nxt_lamp_st = RNSI_LAMP_GAP;
          nxt_lamp_ms = '0;
        end
      end
      RNSI_LAMP_GAP: begin
        // RULE7 RULE8 RULE9 off-phase per cadence
        if (ms_tick && lamp_ms_ff == off_ms(cad_ff) - MS_W'(1)) begin
          nxt_lamp_st = RNSI_LAMP_ON;
          nxt_lamp_ms = '0;
          // RULE11 cadence latched at on-phase
          nxt_cad     = I_NET;
        end
      end
      default: begin
        nxt_lamp_ms = '0;
        if (I_NET != RNSI_NET_OFF) begin
          nxt_lamp_st = RNSI_LAMP_ON;
          nxt_cad     = I_NET;
        end
      end
    endcase
    // RULE6 core stopped forces off at once
    if (I_NET == RNSI_NET_OFF) begin
      nxt_lamp_st = RNSI_LAMP_OFF;
      nxt_lamp_ms = '0;
      nxt_cad     = RNSI_NET_OFF;
    end
  end

  // lamp state; output taken from next state so it needs no extra cycle
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      lamp_st_ff <= RNSI_LAMP_OFF;
      lamp_ms_ff <= '0;
      cad_ff     <= RNSI_NET_OFF;
      lamp_ff    <= 1'b0;
    end else if (I_CE) begin
      lamp_st_ff <= nxt_lamp_st;
      lamp_ms_ff <= nxt_lamp_ms;
      cad_ff     <= nxt_cad;
      lamp_ff    <= (nxt_lamp_st == RNSI_LAMP_ON);
    end
  end

  assign O_RING_N             = ring_n_ff;
  assign O_NETWORK_STATE_LAMP = lamp_ff;

  // checks
  ring_rest_a: assert property (@(posedge I_CORE_CLK) !I_NRST |=> O_RING_N) // RULE10
    else $error("ring not high after reset");
  call_low_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // RULE1
    I_CE && I_EVT.voice_ring && !I_EVT.originating |=> !O_RING_N)
    else $error("voice ring did not pull line low");
  data_low_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // RULE2
    I_CE && I_EVT.data_ring && !I_EVT.originating |=> !O_RING_N)
    else $error("data ring did not pull line low");
  call_end_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // RULE1
    I_CE && ri_st_ff == RI_CALL && I_EVT.call_end && !I_EVT.voice_ring
    && !I_EVT.data_ring |=> O_RING_N)
    else $error("ring not released on call end");
  sms_pulse_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // RULE3
    I_CE && ri_st_ff == RI_PULSE && ms_tick && ri_ms_ff == MS_W'(PULSE_MS - 1)
    && !I_EVT.sms_rx && !I_EVT.urc && !I_EVT.voice_ring && !I_EVT.data_ring
    |=> O_RING_N)
    else $error("pulse did not end at 120ms");
  urc_start_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // RULE4
    I_CE && ri_st_ff != RI_CALL && I_EVT.urc && !I_EVT.originating
    |=> !O_RING_N && ri_ms_ff == '0)
    else $error("report pulse not started");
  caller_high_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // RULE5
    I_CE && I_EVT.originating && ri_st_ff == RI_IDLE |=> O_RING_N)
    else $error("ring dropped while originating");
  lamp_off_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // RULE6
    I_CE && I_NET == RNSI_NET_OFF |=> !O_NETWORK_STATE_LAMP)
    else $error("lamp lit while core stopped");
  lamp_gap_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // RULE8
    lamp_st_ff == RNSI_LAMP_GAP |-> lamp_ms_ff < off_ms(cad_ff))
    else $error("off phase overran its length");
  lamp_on_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // RULE7
    lamp_st_ff == RNSI_LAMP_ON |-> lamp_ms_ff < MS_W'(LAMP_ON_MS))
    else $error("on phase overran 64ms");
  cad_hold_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // RULE11
    lamp_st_ff == RNSI_LAMP_GAP && I_NET != RNSI_NET_OFF && $past(lamp_st_ff)
    == RNSI_LAMP_GAP |-> $stable(cad_ff))
    else $error("cadence changed mid off phase");
  data_gap_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // RULE9
    I_CE && lamp_st_ff == RNSI_LAMP_GAP && cad_ff == RNSI_NET_DATA && ms_tick
    && lamp_ms_ff == MS_W'(OFF_DATA_MS - 1) && I_NET != RNSI_NET_OFF
    |=> O_NETWORK_STATE_LAMP)
    else $error("packet off phase did not end on time");
  ce_freeze_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // enable low freezes ring and lamp state
    !I_CE |=> $stable(ri_st_ff) && $stable(ri_ms_ff) && $stable(lamp_st_ff))
    else $error("state moved while enable low");
endmodule

// File: design/rnsi_pkg.sv
package rnsi_pkg;
  // clock rate and interval figures
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned MS_DIV        = 1000;
  localparam int unsigned PULSE_MS      = 120;
  localparam int unsigned LAMP_ON_MS    = 64;
  localparam int unsigned OFF_UNREG_MS  = 800;
  localparam int unsigned OFF_REG_MS    = 3000;
  localparam int unsigned OFF_DATA_MS   = 300;
  // cycles per millisecond, rounded down, never below one
  localparam int unsigned CYC_PER_MS    = (CLK_HZ / MS_DIV < 1) ? 1 : CLK_HZ / MS_DIV;
  localparam int unsigned MS_W          = 12;
  localparam int unsigned TICK_W        = 16;

  // network state as reported by the modem core
  typedef enum logic [1:0] {
    RNSI_NET_OFF   = 2'h0,
    RNSI_NET_UNREG = 2'h1,
    RNSI_NET_REG   = 2'h2,
    RNSI_NET_DATA  = 2'h3
  } rnsi_net_t;

  // call and event inputs, all one-cycle pulses except the levels
  typedef struct packed {
    logic voice_ring;   // incoming voice call starts ringing (pulse)
    logic data_ring;    // incoming data call starts ringing (pulse)
    logic call_end;     // call established or hung up (pulse)
    logic sms_rx;       // short message received (pulse)
    logic urc;          // unsolicited report issued (pulse)
    logic originating;  // device is caller (level)
  } rnsi_evt_t;

  localparam logic [1:0] RI_IDLE  = 2'h0;
  localparam logic [1:0] RI_CALL  = 2'h1;
  localparam logic [1:0] RI_PULSE = 2'h2;
endpackage

// File: design/rnsi_ms_tick.sv
`timescale 1ns/100ps
// millisecond tick generator, counts core clocks
module rnsi_ms_tick #(
  parameter int unsigned CYC = rnsi_pkg::CYC_PER_MS
) (
  input  wire logic i_clk,
  input  wire logic i_nrst,
  input  wire logic i_ce,
  output logic      o_tick
);
  import rnsi_pkg::*;
  logic [TICK_W-1:0] cnt_ff;
  logic [TICK_W-1:0] nxt_cnt;

  // wrap at the cycle count, tick on the wrap
  always_comb begin
    if (cnt_ff == TICK_W'(CYC - 1)) begin
      nxt_cnt = '0;
    end else begin
      nxt_cnt = cnt_ff + TICK_W'(1);
    end
  end

  // count held while enable low, so tick phase survives a freeze
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      cnt_ff <= '0;
    end else if (i_ce) begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign o_tick = i_ce && (cnt_ff == TICK_W'(CYC - 1));
endmodule

// File: verification/rnsi_host_mon.sv
`timescale 1ns/100ps
// host side: times each low stretch of the ring line
module rnsi_host_mon (
  // clock and watched line
  input  wire logic   i_clk,
  input  wire logic   i_ring_n,
  // length of last low stretch, count of falls
  output logic [31:0] o_low_len,
  output logic [31:0] o_falls
);
  logic [31:0] run;
  initial begin
    run = 32'h0;
    o_low_len = 32'h0;
    o_falls = 32'h0;
  end
  // old value seen at the edge, so counts are whole cycles
  always @(posedge i_clk) begin
    if (i_ring_n === 1'b0) begin
      if (run == 32'h0) o_falls <= o_falls + 32'h1;
      run <= run + 32'h1;
    end else if (run != 32'h0) begin
      o_low_len <= run;
      run <= 32'h0;
    end
  end
endmodule

// File: verification/ring_and_net_status_indicator_test.sv
`timescale 1ns/100ps
// bench for the ring line and the network lamp
module ring_and_net_status_indicator_test;
  import rnsi_pkg::*;
  localparam int P = 4;  // short millisecond keeps the run brief
  typedef struct { logic [5:0] e; int hold; int lo; int hi; } rnsi_row_t;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        ce = 1'b1;
  rnsi_evt_t   evt = '0;
  rnsi_net_t   net = RNSI_NET_OFF;
  logic        ring_n;
  logic        lamp;
  logic [31:0] len;
  logic [31:0] falls;
  int          miscompares = 0;
  int          num_checks = 0;
  int          h;
  int          l;
  int          f0;
  rnsi_row_t   rows [4] = '{'{6'h20, 9, 11, 11}, '{6'h10, 30, 32, 32},
                            '{6'h04, 0, 119*P+1, 120*P}, '{6'h02, 0, 119*P+1, 120*P}};
  int          offs [3] = '{800, 3000, 300};

  always #12.5 clk = ~clk;

  rnsi_top #(.CYC_MS(P)) dut (.I_CORE_CLK(clk), .I_NRST(nrst), .I_CE(ce), .I_EVT(evt),
    .I_NET(net), .O_RING_N(ring_n), .O_NETWORK_STATE_LAMP(lamp));
  rnsi_host_mon host (.i_clk(clk), .i_ring_n(ring_n), .o_low_len(len), .o_falls(falls));

  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  // one-cycle event, originating level kept
  task automatic pulse(logic [5:0] e);
    @(posedge clk) evt <= rnsi_evt_t'(e | {5'h0, evt.originating});
    @(posedge clk) evt <= rnsi_evt_t'({5'h0, evt.originating});
  endtask
  // bounded wait for the ring line to rest, then let the host latch
  task automatic ring_rest();
    // step off the edge first: the line's new value lands after it
    @(negedge clk);
    for (int n = 0; n < 2000 && ring_n !== 1'b1; n++) @(negedge clk);
    repeat (2) @(negedge clk);
  endtask
  // one full lamp period, from a rising edge
  task automatic lamp_meas(output int hi, output int lo);
    hi = 0;
    lo = 0;
    for (int n = 0; n < 20000 && lamp !== 1'b0; n++) @(negedge clk);
    for (int n = 0; n < 20000 && lamp !== 1'b1; n++) @(negedge clk);
    while (lamp === 1'b1 && hi < 20000) begin
      @(negedge clk);
      hi++;
    end
    while (lamp === 1'b0 && lo < 20000) begin
      @(negedge clk);
      lo++;
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (80000) @(posedge clk);
    miscompares++;
    test_done();
  end

  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    check("ring idle", ring_n, 1'b1);
    check("lamp idle", lamp, 1'b0);
    $display("reset test done");
    foreach (rows[i]) begin
      f0 = falls;
      pulse(rows[i].e);
      if (rows[i].hold > 0) begin
        repeat (rows[i].hold) @(posedge clk);
        pulse(6'h08);
      end
      ring_rest();
      check("low len", (len >= rows[i].lo && len <= rows[i].hi), 1'b1);
      check("falls", falls, f0 + 1);
    end
    $display("row tests done");
    f0 = falls;
    @(posedge clk) evt <= rnsi_evt_t'(6'h01);
    pulse(6'h20);
    repeat (50) @(negedge clk);
    check("orig falls", falls, f0);
    @(posedge clk) evt <= '0;
    $display("originating test done");
    pulse(6'h04);
    repeat (100) @(posedge clk);
    pulse(6'h02);
    ring_rest();
    check("restart len", (len >= 102+119*P+1 && len <= 102+120*P), 1'b1);
    $display("restart test done");
    // enable low stretches the pulse by the frozen cycles
    pulse(6'h04);
    repeat (50) @(posedge clk);
    ce <= 1'b0;
    repeat (100) @(posedge clk);
    ce <= 1'b1;
    ring_rest();
    check("frozen len", (len >= 100+119*P+1 && len <= 100+120*P), 1'b1);
    $display("enable test done");
    foreach (offs[i]) begin
      @(posedge clk) net <= rnsi_net_t'(i + 1);
      lamp_meas(h, l);
      check("lamp on", (h >= 63*P+1 && h <= 64*P), 1'b1);
      check("lamp off", (l >= (offs[i]-1)*P+1 && l <= offs[i]*P), 1'b1);
    end
    @(posedge clk) net <= RNSI_NET_OFF;
    repeat (200) @(negedge clk);
    check("lamp stopped", lamp, 1'b0);
    $display("lamp test done");
    pulse(6'h20);
    repeat (5) @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(negedge clk);
    check("ring in reset", ring_n, 1'b1);
    @(posedge clk) nrst <= 1'b1;
    repeat (2) @(negedge clk);
    check("ring after reset", ring_n, 1'b1);
    check("lamp after reset", lamp, 1'b0);
    $display("mid reset test done");
    test_done();
  end
endmodule
